// ### shared/sso_consts.vh
/*
 * Constants of the servo status-output block: register offsets on the APB
 * slave, field positions, reset values and value ranges.
 * Assumes it is included by bare name from files that need these values.
 */
`ifndef SSO_CONSTS_VH
`define SSO_CONSTS_VH

// Register byte offsets.
`define SSO_REG_CTRL        12'h000
`define SSO_REG_VEL_UNDER   12'h004
`define SSO_REG_VEL_OVER    12'h008
`define SSO_REG_TRQ_UNDER   12'h00C
`define SSO_REG_TRQ_OVER    12'h010
`define SSO_REG_THM_UNDER   12'h014
`define SSO_REG_THM_OVER    12'h018
`define SSO_REG_STATUS      12'h01C
`define SSO_REG_ALARM       12'h020

// Control register fields.
`define SSO_CTRL_NEG_LOGIC  0
`define SSO_CTRL_TRQ_OVER_OPENS 1

// Threshold reset value.
`define SSO_THR_RESET       32'h00000000

// Alarm code register values.
`define SSO_ALM_NONE        8'h00
`define SSO_ALM_SW_TRAVEL   8'hF2
`define SSO_ALM_HW_TRAVEL   8'hF3
`define SSO_ALM_THERMAL     8'hA3

// Fixed-point units: velocity in 0.001 rev/s, percentages in 0.01 %.
`define SSO_VEL_MAX         10000
`define SSO_PCT_MAX         10000

`endif

// ### rtl/sso_status_out.v
/*
 * Servo status-output logic: threshold comparators for velocity, torque
 * command and thermal loading, travel-limit, no-fault, home-complete and
 * origin-defined outputs, with APB access to thresholds and status.
 * Assumes all inputs are synchronous to i_clk and the servo loop, alarm
 * detection and home-return sequencer live outside and drive the inputs.
 */
// Overview of operation
// - Velocity-under closes when absolute velocity is at or below its threshold.
// - Velocity-over closes when absolute velocity is at or above its threshold.
// - Torque-under closes when absolute torque command is at or below threshold.
// - Torque-over changes state when absolute torque reaches its threshold.
// - Thermal-under closes when thermal loading is at or below threshold.
// - Thermal-over closes when thermal loading is at or above threshold.
// - All six thresholds reset to zero.
// - Thermal warning A3 rises when thermal loading reaches the warning level.
// - Travel-limit output closes while any software or hardware limit is active.
// - Limits raise alarm F2 for software and F3 for hardware.
// - Limit during a move keeps in-position open.
// - Limit while stopped leaves in-position unchanged.
// - No-fault output closed without faults, open on any alarm or warning.
// - Home-complete closes only after home return at commanded position home.
// - Commanded position is current position plus position error.
// - Nonzero commanded position opens home-complete until next home return.
// - Origin-defined closes after power-up, opens only while home undefined.
// - Alarms A0, A1, A4 turn servo off and make home undefined.
// - Interrupted home return makes home position undefined.
// - Negative output logic inverts every contact state except thermal warning and servo-off.
`timescale 1ns/1ps
`default_nettype none
`include "sso_consts.vh"

module sso_status_out #(
    parameter VEL_W  = 16,
    parameter PCT_W  = 16,
    parameter POS_W  = 24,
    parameter [15:0] THERMAL_WARN_LEVEL = 16'h2710
) (
    input  wire              i_clk,
    input  wire              i_rst_n,
    // APB slave.
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [11:0]       paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output reg               pready,
    output reg               pslverr,
    // Motor state.
    input  wire [VEL_W-1:0]  i_velocity,
    input  wire [PCT_W-1:0]  i_torque_cmd,
    input  wire [PCT_W-1:0]  i_thermal_load,
    input  wire [POS_W-1:0]  i_cur_position,
    input  wire [POS_W-1:0]  i_pos_error,
    input  wire              i_sw_travel_limit,
    input  wire              i_hw_travel_limit,
    input  wire              i_moving,
    input  wire              i_move_done,
    input  wire              i_other_fault,
    input  wire              i_alarm_sensor,
    input  wire              i_alarm_abs_pos,
    input  wire              i_alarm_overspeed,
    input  wire              i_home_done,
    input  wire              i_home_abort,
    // Status contacts, 1 means closed with positive logic.
    output reg               o_velocity_under_flag,
    output reg               o_velocity_over_flag,
    output reg               o_torque_under_flag,
    output reg               o_torque_over_flag,
    output reg               o_thermal_under_flag,
    output reg               o_thermal_over_flag,
    output reg               o_travel_limit_any_output,
    output reg               o_no_fault_output,
    output reg               o_home_complete_output,
    output reg               o_origin_defined_output,
    output reg               o_in_position_output,
    output reg               o_thermal_warning,
    output reg               o_servo_off,
    output reg  [7:0]        o_alarm_code
);

    ////////////////////////////////////////////////////////////////////////////
    // Register file.
    reg  [1:0]        ctrl_q;
    reg  [VEL_W-1:0]  vel_under_q;
    reg  [VEL_W-1:0]  vel_over_q;
    reg  [PCT_W-1:0]  trq_under_q;
    reg  [PCT_W-1:0]  trq_over_q;
    reg  [PCT_W-1:0]  thm_under_q;
    reg  [PCT_W-1:0]  thm_over_q;

    // Internal state.
    reg               home_valid_q;
    reg               home_defined_q;
    reg               in_pos_q;
    reg  [7:0]        alarm_q;
    reg               warn_q;
    reg               servo_off_q;

    wire              wr_en;
    wire              rd_en;
    wire              addr_ok;
    wire [VEL_W-1:0]  vel_abs;
    wire [PCT_W-1:0]  trq_abs;
    wire [POS_W-1:0]  cmd_pos;
    wire              any_limit;
    wire              home_alarm;
    wire              warn_now;
    wire              fault_now;
    wire              neg;
    wire              trq_over_hit;

    // Threshold reset value, cut to each threshold's width below.
    localparam [31:0] THR_RST = `SSO_THR_RESET;

    // Address decode for the known registers.
    assign addr_ok = (paddr == `SSO_REG_CTRL)      || (paddr == `SSO_REG_VEL_UNDER) ||
                     (paddr == `SSO_REG_VEL_OVER)  || (paddr == `SSO_REG_TRQ_UNDER) ||
                     (paddr == `SSO_REG_TRQ_OVER)  || (paddr == `SSO_REG_THM_UNDER) ||
                     (paddr == `SSO_REG_THM_OVER)  || (paddr == `SSO_REG_STATUS)    ||
                     (paddr == `SSO_REG_ALARM);
    // Access phase with zero wait states: pready is high in every access.
    assign wr_en = psel && penable && pwrite && pready;
    assign rd_en = psel && !penable && !pwrite;

    // Threshold and control register writes.
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            ctrl_q      <= 2'h0;
            vel_under_q <= THR_RST[VEL_W-1:0];
            vel_over_q  <= THR_RST[VEL_W-1:0];
            trq_under_q <= THR_RST[PCT_W-1:0];
            trq_over_q  <= THR_RST[PCT_W-1:0];
            thm_under_q <= THR_RST[PCT_W-1:0];
            thm_over_q  <= THR_RST[PCT_W-1:0];
        end else if (wr_en) begin
            case (paddr)
                `SSO_REG_CTRL:      ctrl_q      <= pwdata[1:0];
                `SSO_REG_VEL_UNDER: vel_under_q <= pwdata[VEL_W-1:0];
                `SSO_REG_VEL_OVER:  vel_over_q  <= pwdata[VEL_W-1:0];
                `SSO_REG_TRQ_UNDER: trq_under_q <= pwdata[PCT_W-1:0];
                `SSO_REG_TRQ_OVER:  trq_over_q  <= pwdata[PCT_W-1:0];
                `SSO_REG_THM_UNDER: thm_under_q <= pwdata[PCT_W-1:0];
                `SSO_REG_THM_OVER:  thm_over_q  <= pwdata[PCT_W-1:0];
                default:            ctrl_q      <= ctrl_q;
            endcase
        end
    end

    // APB answer: read data is registered in the setup cycle, ready in access.
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            if (rd_en) begin
                case (paddr)
                    `SSO_REG_CTRL:      prdata <= {30'h0, ctrl_q};
                    `SSO_REG_VEL_UNDER: prdata <= {{(32-VEL_W){1'b0}}, vel_under_q};
                    `SSO_REG_VEL_OVER:  prdata <= {{(32-VEL_W){1'b0}}, vel_over_q};
                    `SSO_REG_TRQ_UNDER: prdata <= {{(32-PCT_W){1'b0}}, trq_under_q};
                    `SSO_REG_TRQ_OVER:  prdata <= {{(32-PCT_W){1'b0}}, trq_over_q};
                    `SSO_REG_THM_UNDER: prdata <= {{(32-PCT_W){1'b0}}, thm_under_q};
                    `SSO_REG_THM_OVER:  prdata <= {{(32-PCT_W){1'b0}}, thm_over_q};
                    `SSO_REG_STATUS:    prdata <= {18'h0, servo_off_q, warn_q, in_pos_q,
                                                   home_defined_q, home_valid_q,
                                                   o_travel_limit_any_output, 2'b00,
                                                   o_thermal_over_flag, o_thermal_under_flag,
                                                   o_torque_over_flag, o_torque_under_flag,
                                                   o_velocity_over_flag, o_velocity_under_flag};
                    `SSO_REG_ALARM:     prdata <= {24'h0, alarm_q};
                    default:            prdata <= 32'h00000000;
                endcase
            end else begin
                // Writes and idle cycles show zero read data.
                prdata <= 32'h00000000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Magnitudes and commanded position, velocity and torque are two's complement.
    assign vel_abs   = i_velocity[VEL_W-1] ? (~i_velocity + 1'b1) : i_velocity;
    assign trq_abs   = i_torque_cmd[PCT_W-1] ? (~i_torque_cmd + 1'b1) : i_torque_cmd;
    assign cmd_pos   = i_cur_position + i_pos_error;
    assign any_limit = i_sw_travel_limit || i_hw_travel_limit;
    assign home_alarm = i_alarm_sensor || i_alarm_abs_pos || i_alarm_overspeed;
    assign warn_now  = (i_thermal_load >= THERMAL_WARN_LEVEL);
    assign fault_now = any_limit || home_alarm || warn_now || i_other_fault;
    assign neg       = ctrl_q[`SSO_CTRL_NEG_LOGIC];
    // Torque-over closes on reach by default; control bit 1 selects opening.
    assign trq_over_hit = (trq_abs >= trq_over_q) ^ ctrl_q[`SSO_CTRL_TRQ_OVER_OPENS];

    // Home position tracking, alarms and in-position state.
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            home_valid_q   <= 1'b0;
            home_defined_q <= 1'b1;
            in_pos_q       <= 1'b0;
            alarm_q        <= `SSO_ALM_NONE;
            warn_q         <= 1'b0;
            servo_off_q    <= 1'b0;
        end else begin
            // Home-complete qualifies on finish at home; moves away drop it.
            if (i_home_done && cmd_pos == {POS_W{1'b0}})
                home_valid_q <= 1'b1;
            else if (cmd_pos != {POS_W{1'b0}} || i_home_abort)
                home_valid_q <= 1'b0;
            // Undefined home wins over a simultaneous finish.
            if (home_alarm || i_home_abort)
                home_defined_q <= 1'b0;
            else if (i_home_done)
                home_defined_q <= 1'b1;
            servo_off_q <= servo_off_q || home_alarm;
            // A limit mid-move keeps in-position open; stopped it is held.
            if (any_limit && i_moving)
                in_pos_q <= 1'b0;
            else if (i_moving)
                in_pos_q <= 1'b0;
            else if (i_move_done && !any_limit)
                in_pos_q <= 1'b1;
            warn_q <= warn_now;
            if (i_sw_travel_limit)
                alarm_q <= `SSO_ALM_SW_TRAVEL;
            else if (i_hw_travel_limit)
                alarm_q <= `SSO_ALM_HW_TRAVEL;
            else if (warn_now)
                alarm_q <= `SSO_ALM_THERMAL;
            else
                alarm_q <= `SSO_ALM_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Contact outputs, registered once per control cycle; polarity skips warning, servo-off and alarm code.
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_velocity_under_flag     <= 1'b0;
            o_velocity_over_flag      <= 1'b0;
            o_torque_under_flag       <= 1'b0;
            o_torque_over_flag        <= 1'b0;
            o_thermal_under_flag      <= 1'b0;
            o_thermal_over_flag       <= 1'b0;
            o_travel_limit_any_output <= 1'b0;
            o_no_fault_output         <= 1'b0;
            o_home_complete_output    <= 1'b0;
            o_origin_defined_output   <= 1'b0;
            o_in_position_output      <= 1'b0;
            o_thermal_warning         <= 1'b0;
            o_servo_off               <= 1'b0;
            o_alarm_code              <= 8'h00;
        end else begin
            o_velocity_under_flag     <= (vel_abs <= vel_under_q) ^ neg;
            o_velocity_over_flag      <= (vel_abs >= vel_over_q) ^ neg;
            o_torque_under_flag       <= (trq_abs <= trq_under_q) ^ neg;
            o_torque_over_flag        <= trq_over_hit ^ neg;
            o_thermal_under_flag      <= (i_thermal_load <= thm_under_q) ^ neg;
            o_thermal_over_flag       <= (i_thermal_load >= thm_over_q) ^ neg;
            o_travel_limit_any_output <= any_limit ^ neg;
            o_no_fault_output         <= (!fault_now) ^ neg;
            o_home_complete_output    <= home_valid_q ^ neg;
            o_origin_defined_output   <= home_defined_q ^ neg;
            o_in_position_output      <= in_pos_q ^ neg;
            o_thermal_warning         <= warn_q;
            o_servo_off               <= servo_off_q;
            o_alarm_code              <= alarm_q;
        end
    end

endmodule // sso_status_out
`default_nettype wire

// ### verif/sso_ctrl_model.sv
/* Machine controller model that reads the thermal-under contact.
   Assumes the thermal-under threshold is 0 and positive logic is set. */
`timescale 1ns/1ps
`default_nettype none
module sso_ctrl_model (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_thermal_under_flag,
    output var  logic o_cycle_ok
);
    // A new cycle may start only while the loading reads zero.
    always @(posedge i_clk) begin
        if (!i_rst_n) o_cycle_ok <= 1'b0;
        else o_cycle_ok <= i_thermal_under_flag;
    end
endmodule // sso_ctrl_model
`default_nettype wire

// ### verif/sso_status_out_properties.sv
/* Port checker of the status-output block.
   Assumes it is bound to sso_status_out and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module sso_status_props (
    input wire logic        i_clk, i_rst_n, psel, penable, pwrite, pready, pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic        i_sw_travel_limit, i_hw_travel_limit,
    input wire logic        i_alarm_sensor, i_alarm_abs_pos, i_alarm_overspeed,
    input wire logic        o_travel_limit_any_output, o_origin_defined_output, o_servo_off,
    input wire logic [7:0]  o_alarm_code
);
    logic neg_q;
    wire lim = i_sw_travel_limit || i_hw_travel_limit;
    wire alm = i_alarm_sensor || i_alarm_abs_pos || i_alarm_overspeed;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // Tracks the output polarity bit written over the bus.
    always @(posedge i_clk) begin
        if (!i_rst_n) neg_q <= 1'b0;
        else if (psel && penable && pready && pwrite && paddr == 12'h000) neg_q <= pwdata[0];
    end
    ////////////////////////////////////////////////////////////////////////
    AST_READY: assert property (psel && !penable |=> pready)
        else $error("no ready in access cycle");
    AST_UNMAPPED: assert property (psel && penable && paddr > 12'h020 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_TRAVEL_CLOSE: assert property ((lim && $stable(neg_q))[*3] |-> o_travel_limit_any_output == !neg_q)
        else $error("travel contact not closed");
    AST_TRAVEL_OPEN: assert property ((!lim && $stable(neg_q))[*3] |-> o_travel_limit_any_output == neg_q)
        else $error("travel contact not open");
    AST_ALARM_SW: assert property (i_sw_travel_limit[*3] |-> o_alarm_code == 8'hF2)
        else $error("software limit code wrong");
    AST_ALARM_HW: assert property ((!i_sw_travel_limit && i_hw_travel_limit)[*3] |-> o_alarm_code == 8'hF3)
        else $error("hardware limit code wrong");
    AST_SERVO_OFF: assert property (alm |-> ##[1:2] o_servo_off)
        else $error("servo not off on alarm");
    AST_ORIGIN_OPEN: assert property (alm |-> ##[1:2] o_origin_defined_output == neg_q)
        else $error("origin contact not open on alarm");
    COV_ERR: cover property (psel && penable && pslverr);
    COV_HW: cover property ((!i_sw_travel_limit && i_hw_travel_limit)[*2]);
    COV_ALM: cover property (alm ##1 o_servo_off);
endmodule // sso_status_props
bind sso_status_out sso_status_props i_props (.i_clk(i_clk), .i_rst_n(i_rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .i_sw_travel_limit(i_sw_travel_limit), .i_hw_travel_limit(i_hw_travel_limit), .i_alarm_sensor(i_alarm_sensor),
    .i_alarm_abs_pos(i_alarm_abs_pos), .i_alarm_overspeed(i_alarm_overspeed), .o_servo_off(o_servo_off),
    .o_travel_limit_any_output(o_travel_limit_any_output), .o_origin_defined_output(o_origin_defined_output),
    .o_alarm_code(o_alarm_code));
`default_nettype wire

// ### verif/tb_top.sv
/* Self-checking bench of the status-output block.
   Assumes the block answers bus setups in the next cycle. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {logic [15:0] v, t, j; logic [5:0] f;} sso_row_t;
    logic        i_clk, i_rst_n, psel, penable, pwrite, pready, pslverr, err, ok;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] vel, trq, thm;
    logic [23:0] cur, perr;
    logic [2:0]  alm;
    logic [5:0]  fl;
    logic [7:0]  ac;
    logic        sw, hw, mov, mdone, oth, hdone, habt, tl, nf, hc, od, ip, tw, so;
    int          n_errors = 0, cmp_count = 0, i;
    int          thr [6] = '{1000, 5000, 2000, 8000, 3000, 6000};
    sso_row_t    rows [5] = '{'{16'h03E8, 16'h07D0, 16'h0BB8, 6'h15}, '{16'hFC18, 16'hF830, 16'h0BB9, 6'h05},
        '{16'h03E9, 16'h07D1, 16'h1770, 6'h20}, '{16'hEC78, 16'hE0C0, 16'h2710, 6'h2A},
        '{16'h1387, 16'h1F3F, 16'h176F, 6'h00}};
    sso_status_out i_sso_status_out (.i_clk(i_clk), .i_rst_n(i_rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .i_velocity(vel), .i_torque_cmd(trq), .i_thermal_load(thm), .i_cur_position(cur), .i_pos_error(perr),
        .i_sw_travel_limit(sw), .i_hw_travel_limit(hw), .i_moving(mov), .i_move_done(mdone), .i_other_fault(oth),
        .i_alarm_sensor(alm[0]), .i_alarm_abs_pos(alm[1]), .i_alarm_overspeed(alm[2]), .i_home_done(hdone),
        .i_home_abort(habt), .o_velocity_under_flag(fl[0]), .o_velocity_over_flag(fl[1]),
        .o_torque_under_flag(fl[2]), .o_torque_over_flag(fl[3]), .o_thermal_under_flag(fl[4]),
        .o_thermal_over_flag(fl[5]), .o_travel_limit_any_output(tl), .o_no_fault_output(nf),
        .o_home_complete_output(hc), .o_origin_defined_output(od), .o_in_position_output(ip),
        .o_thermal_warning(tw), .o_servo_off(so), .o_alarm_code(ac));
    sso_ctrl_model i_sso_ctrl_model (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_thermal_under_flag(fl[4]), .o_cycle_ok(ok));
    ////////////////////////////////////////////////////////////////////////
    // Compares one value and reports a mismatch.
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task results;
        if (n_errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task settle(input int n);
        repeat (n + 1) @(posedge i_clk);
    endtask
    // One bus transfer; read data and error are taken in the access cycle.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        // Values read right after the edge are those the edge sampled.
        do begin
            @(posedge i_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk("pready", 1, pready);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task do_reset;
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        settle(3);
    endtask
    initial begin
        i_clk = 0;
        forever #20 i_clk = ~i_clk;
    end
    initial begin
        #400000 n_errors++;
        results();
    end
    // Main sequence: reset and register checks, table rows, then the hand-written cases.
    initial begin
        {i_rst_n, psel, penable, pwrite, paddr, pwdata, vel, trq, thm, cur, perr} = '0;
        {alm, sw, hw, mov, mdone, oth, hdone, habt} = '0;
        do_reset();
        chk("flags", 6'h3F, fl);
        chk("origin", 1, od);
        chk("cycle ok", 1, ok);
        for (i = 0; i < 6; i++) begin
            apb(1'b0, 12'h004 + 4 * i, 0);
            chk("threshold", 0, rd);
            apb(1'b1, 12'h004 + 4 * i, thr[i]);
        end
        apb(1'b0, 12'h040, 0);
        chk("slverr", 1, err);
        chk("rdata", 0, rd);
        for (i = 0; i < 5; i++) begin
            @(posedge i_clk);
            vel <= rows[i].v; trq <= rows[i].t; thm <= rows[i].j;
            settle(2);
            chk("flags", rows[i].f, fl);
        end
        apb(1'b1, 12'h000, 1);
        settle(3);
        chk("inverted flags", 6'h3F, fl);
        apb(1'b1, 12'h000, 2);
        trq <= 16'h2328;
        settle(3);
        chk("torque over opens", 0, fl);
        apb(1'b1, 12'h000, 0);
        sw <= 1'b1;
        settle(3);
        chk("travel", 1, tl);
        chk("alarm code", 8'hF2, ac);
        {sw, hw} <= 2'b01;
        settle(3);
        chk("alarm code", 8'hF3, ac);
        hw <= 1'b0;
        mdone <= 1'b1;
        settle(0);
        mdone <= 1'b0;
        settle(3);
        chk("in position", 1, ip);
        sw <= 1'b1;
        settle(3);
        chk("in position held", 1, ip);
        mov <= 1'b1;
        settle(3);
        mdone <= 1'b1;
        settle(0);
        mdone <= 1'b0;
        settle(3);
        chk("in position moving", 0, ip);
        {sw, mov, thm} <= {2'b00, 16'h2710};
        settle(3);
        chk("warning", 1, tw);
        chk("alarm code", 8'hA3, ac);
        chk("no fault", 0, nf);
        {thm, oth} <= {16'h0000, 1'b1};
        settle(3);
        chk("no fault", 0, nf);
        {oth, cur, perr, hdone} <= {1'b0, 24'h000005, 24'hFFFFFB, 1'b1};
        settle(0);
        hdone <= 1'b0;
        settle(3);
        chk("no fault", 1, nf);
        chk("home complete", 1, hc);
        perr <= 24'h000000;
        settle(3);
        chk("home complete", 0, hc);
        {cur, habt} <= {24'h000000, 1'b1};
        settle(0);
        habt <= 1'b0;
        settle(3);
        chk("home complete", 0, hc);
        chk("origin", 0, od);
        for (i = 0; i < 3; i++) begin
            do_reset();
            chk("origin", 1, od);
            alm <= 3'b001 << i;
            settle(3);
            chk("servo off", 1, so);
            chk("origin", 0, od);
            alm <= 3'b000;
        end
        results();
    end
endmodule // tb_top
`default_nettype wire
